// *** rtl/ftac_top.sv ***
// Table read/write and self-timed flash sequencer.
// Assumes a flash macro answering reads by rd_ack
// and an AXI4-Lite master on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ftac_top
    import ftac_pkg::*;
#(
    parameter int unsigned LONG_CNT = LONG_CYCLES
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         por_n,
    input  wire logic         s_awvalid,
    output logic              s_awready,
    input  wire logic [7:0]   s_awaddr,
    input  wire logic         s_wvalid,
    output logic              s_wready,
    input  wire logic [31:0]  s_wdata,
    input  wire logic [3:0]   s_wstrb,
    output logic              s_bvalid,
    input  wire logic         s_bready,
    output logic [1:0]        s_bresp,
    input  wire logic         s_arvalid,
    output logic              s_arready,
    input  wire logic [7:0]   s_araddr,
    output logic              s_rvalid,
    input  wire logic         s_rready,
    output logic [31:0]       s_rdata,
    output logic [1:0]        s_rresp,
    output ftac_flash_cmd_s   flash_cmd,
    input  wire logic         flash_rd_ack,
    input  wire logic [7:0]   flash_rd_data,
    output logic [63:0][7:0]  flash_prog_data,
    input  wire logic [15:0]  fetch_word,
    input  wire logic         fetch_legal,
    input  wire logic         fetch_valid,
    output logic              fetch_stall,
    output logic [15:0]       issue_word,
    output logic              issue_valid
);
    localparam int CW = $clog2(LONG_CNT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LONG_CNT - 1);

    // Known register addresses
    function automatic logic addr_known(input logic [7:0] a);
        return (a[7:5] == 3'b000) && (a[1:0] == 2'b00);
    endfunction

    // ************************************************
    // AXI4-Lite write channel
    // ************************************************
    logic        aw_held_reg, aw_held_next;
    logic [7:0]  awaddr_reg, awaddr_next;
    logic        w_held_reg, w_held_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        wstrb_reg, wstrb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        wr_fire;

    assign s_awready = !aw_held_reg;
    assign s_wready  = !w_held_reg;
    assign s_bvalid  = bvalid_reg;
    assign s_bresp   = bresp_reg;
    assign wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;

    // Hold address and data in either order
    always_comb begin
        aw_held_next = aw_held_reg;
        awaddr_next  = awaddr_reg;
        w_held_next  = w_held_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_awvalid && !aw_held_reg) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_awaddr;
        end
        if (s_wvalid && !w_held_reg) begin
            w_held_next = 1'b1;
            wdata_next  = s_wdata[7:0];
            wstrb_next  = s_wstrb[0];
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = addr_known(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= BYTE_RESET;
            w_held_reg  <= 1'b0;
            wdata_reg   <= BYTE_RESET;
            wstrb_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            awaddr_reg  <= awaddr_next;
            w_held_reg  <= w_held_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    // ************************************************
    // Sequencer state
    // ************************************************
    ftac_state_e     state_reg, state_next;
    ftac_ptr_mode_e  mode_reg, mode_next;
    logic [21:0]     ptr_reg, ptr_next;
    logic [7:0]      latch_reg, latch_next;
    logic            free_reg, free_next;
    logic            err_reg, err_next;
    logic            program_write_allow_reg, program_write_allow_next;
    logic            wr_reg, wr_next;
    logic            key1_reg, key1_next;
    logic            armed_reg, armed_next;
    logic            erase_reg, erase_next;
    logic [CW-1:0]   cnt_reg, cnt_next;
    ftac_flash_cmd_s cmd_reg, cmd_next;
    logic [63:0][7:0] hold_reg, hold_next;
    logic            hold_we;
    logic [5:0]      hold_idx;
    logic [21:0]     acc_addr;
    logic            sw_wr;
    logic            long_done;

    assign sw_wr     = wr_fire && wstrb_reg;
    assign long_done = (state_reg == ST_LONG) && (cnt_reg == CNT_LAST);

    // Main next-state logic
    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        ptr_next   = ptr_reg;
        latch_next = latch_reg;
        free_next  = free_reg;
        err_next   = err_reg;
        program_write_allow_next  = program_write_allow_reg;
        wr_next    = wr_reg;
        key1_next  = key1_reg;
        armed_next = armed_reg;
        erase_next = erase_reg;
        cnt_next   = cnt_reg;
        cmd_next   = cmd_reg;
        hold_we    = 1'b0;
        hold_idx   = 6'h00;
        acc_addr   = ptr_reg;
        cmd_next.rd_req      = 1'b0;
        cmd_next.prog_start  = 1'b0;
        cmd_next.erase_start = 1'b0;
        // Return one byte into the latch
        if (state_reg == ST_RD_WAIT && flash_rd_ack) begin
            latch_next = flash_rd_data; // see R1
            state_next = ST_IDLE;
            if (mode_reg == PTR_POST_INC) begin
                ptr_next = ftac_ptr_step(ptr_reg, 1'b0); // see R14
            end else if (mode_reg == PTR_POST_DEC) begin
                ptr_next = ftac_ptr_step(ptr_reg, 1'b1);
            end
        end
        // Self-timed operation ends on the timer
        if (state_reg == ST_LONG) begin
            cnt_next = cnt_reg + CW'(1); // see R23
            if (long_done) begin
                state_next = ST_IDLE; // see R5
                wr_next    = 1'b0; // see R20
                err_next   = 1'b0; // see R19
                if (erase_reg) begin
                    free_next = 1'b0; // see R17
                end
            end
        end
        if (sw_wr) begin
            armed_next = 1'b0; // see R22
            key1_next  = 1'b0;
            case (awaddr_reg)
                PTR_LOW_ADDR: begin
                    if (state_reg == ST_IDLE) begin
                        ptr_next[7:0] = wdata_reg; // see R12
                    end
                end
                PTR_HIGH_ADDR: begin
                    if (state_reg == ST_IDLE) begin
                        ptr_next[15:8] = wdata_reg;
                    end
                end
                PTR_UPPR_ADDR: begin
                    if (state_reg == ST_IDLE) begin
                        ptr_next[21:16] = wdata_reg[5:0];
                    end
                end
                LATCH_ADDR: begin
                    if (state_reg == ST_IDLE) begin
                        latch_next = wdata_reg; // see R7
                    end
                end
                UNLOCK_ADDR: begin
                    // Two-key sequence, nothing stored
                    key1_next  = (wdata_reg == KEY_FIRST);
                    armed_next = key1_reg && (wdata_reg == KEY_SECOND); // see R16
                end
                CTRL_ADDR: begin
                    free_next = wdata_reg[FREE_BIT];
                    program_write_allow_next = wdata_reg[PROGRAM_WRITE_ALLOW_BIT]; // see R18
                    if (!(wdata_reg[WR_BIT] && state_reg == ST_LONG)) begin
                        err_next = wdata_reg[ERR_BIT];
                    end
                    // Start only when idle; zero has no effect
                    if (wdata_reg[WR_BIT] && state_reg == ST_IDLE) begin
                        err_next = 1'b1; // see R19
                        if (armed_reg && wdata_reg[PROGRAM_WRITE_ALLOW_BIT]) begin // see R25
                            wr_next    = 1'b1; // see R20
                            state_next = ST_LONG;
                            cnt_next   = '0;
                            erase_next = wdata_reg[FREE_BIT];
                            if (wdata_reg[FREE_BIT]) begin
                                cmd_next.erase_start = 1'b1; // see R3, R4
                                cmd_next.erase_block = ptr_reg[20:10]; // see R11
                            end else begin
                                cmd_next.prog_start = 1'b1; // see R2
                                cmd_next.prog_block = ptr_reg[20:6]; // see R10
                            end
                        end
                    end
                end
                CMD_ADDR: begin
                    if (state_reg == ST_IDLE) begin
                        mode_next = ftac_ptr_mode_e'(wdata_reg[2:1]); // see R15
                        if (wdata_reg[2:1] == PTR_PRE_INC) begin
                            acc_addr = ftac_ptr_step(ptr_reg, 1'b0);
                            ptr_next = acc_addr;
                        end
                        if (wdata_reg[CMD_OP_BIT]) begin
                            // Short write into a holding byte
                            hold_we  = 1'b1; // see R9
                            hold_idx = acc_addr[5:0]; // see R8
                            if (wdata_reg[2:1] == PTR_POST_INC) begin
                                ptr_next = ftac_ptr_step(ptr_reg, 1'b0);
                            end else if (wdata_reg[2:1] == PTR_POST_DEC) begin
                                ptr_next = ftac_ptr_step(ptr_reg, 1'b1);
                            end
                        end else begin
                            cmd_next.rd_req  = 1'b1;
                            cmd_next.rd_addr = acc_addr; // see R13
                            state_next       = ST_RD_WAIT;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Reset aborting a long write leaves the error set
        if (!aresetn) begin
            err_next = err_reg || (state_reg == ST_LONG); // see R19
        end
    end

    // Holding bytes, never cleared by programming
    always_comb begin
        hold_next = hold_reg; // see R24
        if (hold_we) begin
            hold_next[hold_idx] = latch_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!por_n) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            mode_reg  <= PTR_KEEP;
            ptr_reg   <= '0;
            latch_reg <= BYTE_RESET;
            free_reg  <= 1'b0;
            program_write_allow_reg  <= 1'b0;
            wr_reg    <= 1'b0;
            key1_reg  <= 1'b0;
            armed_reg <= 1'b0;
            erase_reg <= 1'b0;
            cnt_reg   <= '0;
            cmd_reg   <= '0;
            hold_reg  <= '0;
        end else begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
            ptr_reg   <= ptr_next;
            latch_reg <= latch_next;
            free_reg  <= free_next;
            program_write_allow_reg  <= program_write_allow_next;
            wr_reg    <= wr_next;
            key1_reg  <= key1_next;
            armed_reg <= armed_next;
            erase_reg <= erase_next;
            cnt_reg   <= cnt_next;
            cmd_reg   <= cmd_next;
            hold_reg  <= hold_next;
        end
    end

    assign flash_cmd       = cmd_reg;
    assign flash_prog_data = hold_reg;
    assign fetch_stall     = (state_reg == ST_LONG); // see R5

    // ************************************************
    // Fetch path
    // ************************************************
    logic [15:0] iw_reg, iw_next;
    logic        iv_reg, iv_next;

    // Illegal words issue as no-op; none while stalled
    always_comb begin
        iw_next = fetch_legal ? fetch_word : NOP_WORD; // see R6
        iv_next = fetch_valid && !fetch_stall;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iw_reg <= NOP_WORD;
            iv_reg <= 1'b0;
        end else begin
            iw_reg <= iw_next;
            iv_reg <= iv_next;
        end
    end

    assign issue_word  = iw_reg;
    assign issue_valid = iv_reg;

    // ************************************************
    // AXI4-Lite read channel
    // ************************************************
    logic        rvalid_reg, rvalid_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;

    assign s_arready = !rvalid_reg;
    assign s_rvalid  = rvalid_reg;
    assign s_rdata   = {24'h000000, rdata_reg};
    assign s_rresp   = rresp_reg;

    // Read multiplexer
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (s_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = addr_known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_araddr)
                PTR_LOW_ADDR:  rdata_next = ptr_reg[7:0];
                PTR_HIGH_ADDR: rdata_next = ptr_reg[15:8];
                PTR_UPPR_ADDR: rdata_next = {2'b00, ptr_reg[21:16]};
                LATCH_ADDR:    rdata_next = latch_reg;
                CTRL_ADDR:     rdata_next = {3'b000, free_reg, err_reg,
                                             program_write_allow_reg, wr_reg, 1'b0}; // see R21
                CMD_ADDR:      rdata_next = {5'h00, mode_reg, 1'b0};
                STAT_ADDR:     rdata_next = {6'h00, fetch_stall,
                                             state_reg == ST_RD_WAIT};
                default:       rdata_next = BYTE_RESET; // see R16
            endcase
        end else if (rvalid_reg && s_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= BYTE_RESET;
            rresp_reg  <= RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    property p_rd_latch;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_RD_WAIT && flash_rd_ack)
            |=> latch_reg == $past(flash_rd_data);
    endproperty
    a_rd_latch: assert property (p_rd_latch) // see R1
        else $error("latch missed read byte");

    property p_hold_fill;
        @(posedge aclk) disable iff (!aresetn)
        hold_we |=> hold_reg[$past(hold_idx)] == $past(latch_reg);
    endproperty
    a_hold_fill: assert property (p_hold_fill) // see R9
        else $error("holding byte not written");

    property p_prog_blk;
        @(posedge aclk) disable iff (!aresetn)
        flash_cmd.prog_start |-> flash_cmd.prog_block == ptr_reg[20:6]
            && fetch_stall && program_write_allow_reg;
    endproperty
    a_prog_blk: assert property (p_prog_blk) // see R10
        else $error("wrong program block");

    property p_erase_blk;
        @(posedge aclk) disable iff (!aresetn)
        flash_cmd.erase_start |-> flash_cmd.erase_block == ptr_reg[20:10]
            && program_write_allow_reg;
    endproperty
    a_erase_blk: assert property (p_erase_blk) // see R11
        else $error("wrong erase block");

    property p_top_bit;
        @(posedge aclk) disable iff (!aresetn)
        !(sw_wr && awaddr_reg == PTR_UPPR_ADDR)
            |=> $stable(ptr_reg[21]);
    endproperty
    a_top_bit: assert property (p_top_bit) // see R14
        else $error("pointer top bit moved");

    property p_unlock_zero;
        @(posedge aclk) disable iff (!aresetn)
        (s_arvalid && s_arready && s_araddr == UNLOCK_ADDR)
            |=> s_rvalid && s_rdata == 32'h00000000;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero) // see R16
        else $error("unlock port read nonzero");

    property p_wr_clear;
        @(posedge aclk) disable iff (!aresetn)
        $fell(wr_reg) && $past(aresetn) |-> $past(long_done) && !fetch_stall;
    endproperty
    a_wr_clear: assert property (p_wr_clear) // see R20
        else $error("start bit cleared early");

    property p_err_on_start;
        @(posedge aclk) disable iff (!aresetn)
        $rose(wr_reg) |-> err_reg ##1 err_reg;
    endproperty
    a_err_on_start: assert property (p_err_on_start) // see R19
        else $error("error flag not set at start");

    property p_no_bad_start;
        @(posedge aclk) disable iff (!aresetn)
        $rose(fetch_stall) |-> $past(armed_reg) && program_write_allow_reg && wr_reg;
    endproperty
    a_no_bad_start: assert property (p_no_bad_start) // see R25
        else $error("cycle started without unlock");

    property p_stall_len;
        @(posedge aclk) disable iff (!aresetn)
        fetch_stall |-> cnt_reg <= CNT_LAST ##1 !issue_valid;
    endproperty
    a_stall_len: assert property (p_stall_len) // see R5
        else $error("stall counter overran");
endmodule
`default_nettype wire

// *** rtl/ftac_pkg.sv ***
// Constants, types and helpers of the flash table access block.
// Assumes a 100 MHz core clock and an AXI4-Lite register master.
// Summary of operation
// R1: Table read loads one byte into latch
// R2: Programming uses whole 64-byte blocks only
// R3: Core-started erase clears one 1024-byte block
// R4: No whole-array erase from the core
// R5: Fetch stalls until programming timer ends
// R6: Illegal fetched word executes as no-op
// R7: Program data moves only through latch
// R8: Table accesses are byte granular
// R9: Table write fills holding byte ptr[5:0]
// R10: Pointer bits 20:6 select program block
// R11: Pointer bits 20:10 select erase block
// R12: Pointer is 22 bits from three bytes
// R13: Table read uses all 22 pointer bits
// R14: Auto adjust changes only low 21 bits
// R15: Keep, post-inc, post-dec or pre-inc pointer
// R16: Unlock port stores nothing, reads zero
// R17: Erase-select makes next start an erase
// R18: Writes need write-allow, clear after reset
// R19: Error sets on start, clears on completion
// R20: Start bit only settable, hardware clears
// R21: Control bits 7:5 and 0 read zero
// R22: Software writes 55h then AAh first
// R23: Long write stalls about two milliseconds
// R24: Holding registers survive programming
// R25: No cycle without write-allow and unlock
package ftac_pkg;
    // ************************************************
    // Register map (byte addresses)
    // ************************************************
    localparam logic [7:0] PTR_LOW_ADDR  = 8'h00;
    localparam logic [7:0] PTR_HIGH_ADDR = 8'h04;
    localparam logic [7:0] PTR_UPPR_ADDR = 8'h08;
    localparam logic [7:0] LATCH_ADDR    = 8'h0C;
    localparam logic [7:0] CTRL_ADDR     = 8'h10;
    localparam logic [7:0] UNLOCK_ADDR   = 8'h14;
    localparam logic [7:0] CMD_ADDR      = 8'h18;
    localparam logic [7:0] STAT_ADDR     = 8'h1C;
    // ************************************************
    // Fields, keys and reset values
    // ************************************************
    localparam int FREE_BIT = 4;
    localparam int ERR_BIT  = 3;
    localparam int PROGRAM_WRITE_ALLOW_BIT = 2;
    localparam int WR_BIT   = 1;
    localparam int CMD_OP_BIT = 0;
    localparam logic [7:0]  KEY_FIRST  = 8'h55;
    localparam logic [7:0]  KEY_SECOND = 8'hAA;
    localparam logic [15:0] NOP_WORD   = 16'h0000;
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Long write time and its cycle count
    localparam int LONG_TIME_NS = 2000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LONG_CYCLES = LONG_TIME_NS / CLK_PERIOD_NS;
    // ************************************************
    // Types
    // ************************************************
    typedef enum logic [1:0] {
        PTR_KEEP     = 2'b00,
        PTR_POST_INC = 2'b01,
        PTR_POST_DEC = 2'b10,
        PTR_PRE_INC  = 2'b11
    } ftac_ptr_mode_e;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RD_WAIT = 2'b01,
        ST_LONG    = 2'b10
    } ftac_state_e;
    typedef struct packed {
        logic        rd_req;
        logic [21:0] rd_addr;
        logic        prog_start;
        logic [14:0] prog_block;
        logic        erase_start;
        logic [10:0] erase_block;
    } ftac_flash_cmd_s;
    // Step low 21 pointer bits, keep the top bit
    function automatic logic [21:0] ftac_ptr_step(
        input logic [21:0] p,
        input logic        dec);
        logic [20:0] low;
        low = dec ? p[20:0] - 21'h1 : p[20:0] + 21'h1;
        return {p[21], low};
    endfunction
endpackage

// *** testbench/ftac_flash_model.sv ***
// Flash array model: answers table reads.
// Assumes the sequencer's command struct on aclk.
`timescale 1ns/1ns
`default_nettype none
module ftac_flash_model
    import ftac_pkg::*;
(
    input  wire logic            aclk,
    input  wire ftac_flash_cmd_s flash_cmd,
    output logic                 flash_rd_ack,
    output logic [7:0]           flash_rd_data
);
    // ****
    // Read answer, odd addresses fast, even slow
    // ****
    logic [2:0] wait_q = 3'h0;
    // Idle data toggles so stale bytes never match
    always @(posedge aclk) begin
        flash_rd_ack <= 1'b0;
        flash_rd_data <= ~flash_rd_data;
        if (flash_cmd.rd_req) begin
            wait_q <= flash_cmd.rd_addr[0] ? 3'h1 : 3'h3;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
            if (wait_q == 3'h1) begin
                flash_rd_ack <= 1'b1;
                flash_rd_data <= flash_cmd.rd_addr[7:0] ^ {flash_cmd.rd_addr[21], flash_cmd.rd_addr[14:8]};
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/ftac_top_bench.sv ***
// Bench for the flash table access block.
// Assumes a short long-write count of 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module ftac_top_bench;
    import ftac_pkg::*;
    // ****
    // Signals, design and flash model
    // ****
    logic aclk = 0, aresetn = 0, por_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, rd_data, d;
    logic [31:0] wdata = 0, rdat, seed = 32'hECEBF678;
    logic [3:0] wstrb = 0;
    logic [1:0] bres, rres, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, rd_ack, stall, iv, fv = 0, fl = 0;
    logic [31:0] rdata;
    logic [15:0] fw = 0, iw;
    logic [63:0][7:0] pd;
    logic [21:0] p, q, a;
    logic [14:0] blk = 0;
    logic [10:0] eblk = 0;
    int miscompares = 0, samples_checked = 0, n_prog = 0;
    ftac_flash_cmd_s cmd;
    always #5 aclk = ~aclk;
    ftac_top #(.LONG_CNT(20)) i_ftac_top (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .s_awvalid(awvalid), .s_awready(awready), .s_awaddr(awaddr), .s_wvalid(wvalid), .s_wready(wready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_bvalid(bvalid), .s_bready(bready), .s_bresp(bresp),
        .s_arvalid(arvalid), .s_arready(arready), .s_araddr(araddr), .s_rvalid(rvalid), .s_rready(rready),
        .s_rdata(rdata), .s_rresp(rresp), .flash_cmd(cmd), .flash_rd_ack(rd_ack), .flash_rd_data(rd_data),
        .flash_prog_data(pd), .fetch_word(fw), .fetch_legal(fl), .fetch_valid(fv), .fetch_stall(stall),
        .issue_word(iw), .issue_valid(iv));
    ftac_flash_model i_ftac_flash_model (.aclk(aclk), .flash_cmd(cmd), .flash_rd_ack(rd_ack),
        .flash_rd_data(rd_data));
    // Counts program start pulses, captures program and erase block numbers
    always @(posedge aclk) begin
        if (cmd.prog_start) begin n_prog <= n_prog + 1; blk <= cmd.prog_block; end
        if (cmd.erase_start) eblk <= cmd.erase_block;
    end
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [21:0] stp(input logic [21:0] v, input logic dn);
        return {v[21], dn ? v[20:0] - 21'h1 : v[20:0] + 21'h1};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin miscompares++; $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp); end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic axw(input logic [7:0] ad, input logic [7:0] dt);
        logic ta, tw;
        ta = 0; tw = 0;
        @(posedge aclk);
        awaddr <= ad; wdata <= {24'h0, dt}; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && awready) begin ta = 1; awvalid <= 0; end
            if (!tw && wready) begin tw = 1; wvalid <= 0; end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bres = bresp; bready <= 0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge aclk);
        araddr <= ad; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rdat = rdata; rres = rresp; rready <= 0;
    endtask
    task automatic setp(input logic [21:0] v);
        axw(PTR_LOW_ADDR, v[7:0]); axw(PTR_HIGH_ADDR, v[15:8]); axw(PTR_UPPR_ADDR, {2'h0, v[21:16]});
    endtask
    task automatic getp(output logic [21:0] v);
        rd(PTR_LOW_ADDR); v[7:0] = rdat[7:0]; rd(PTR_HIGH_ADDR); v[15:8] = rdat[7:0];
        rd(PTR_UPPR_ADDR); v[21:16] = rdat[5:0];
    endtask
    task automatic start(input logic [7:0] c);
        axw(UNLOCK_ADDR, KEY_FIRST); axw(UNLOCK_ADDR, KEY_SECOND); axw(CTRL_ADDR, c);
    endtask
    // Watchdog cuts a hang short
    initial begin repeat (30000) @(posedge aclk); miscompares++; report_and_stop; end
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1; por_n <= 1; fv <= 1; fl <= 1; fw <= seed[15:0];
        rd(CTRL_ADDR); chk(rdat, 32'h0);
        rd(UNLOCK_ADDR); chk(rdat, 32'h0);
        for (int m = 0; m < 4; m++) begin
            setp(22'h3FFFFF); axw(CMD_ADDR, {5'h0, m[1:0], 1'b0});
            do rd(STAT_ADDR); while (rdat[0] !== 1'b0);
            a = (m == 3) ? 22'h200000 : 22'h3FFFFF;
            rd(LATCH_ADDR); chk(rdat, {24'h0, a[7:0] ^ {a[21], a[14:8]}});
            getp(q); chk({10'h0, q}, {10'h0, (m == 1) ? stp(a, 0) : (m == 2) ? stp(a, 1) : a});
        end
        repeat (8) begin
            seed = lfsr(seed); p = seed[21:0]; d = seed[29:22];
            setp(p); axw(LATCH_ADDR, d); axw(CMD_ADDR, 8'h03);
            chk(pd[p[5:0]], d);
        end
        q = stp(p, 0);
        axw(CTRL_ADDR, 8'h06); rd(CTRL_ADDR); chk(rdat, 32'h0C);
        chk(stall, 0); chk(n_prog, 0);
        start(8'h06); chk(stall, 1);
        @(posedge aclk); chk(iv, 0);
        rd(CTRL_ADDR); chk(rdat, 32'h0E);
        while (stall === 1'b1) @(posedge aclk);
        rd(CTRL_ADDR); chk(rdat, 32'h04);
        chk(blk, q[20:6]); chk(n_prog, 1); chk(pd[p[5:0]], d);
        repeat (2) @(posedge aclk); chk(iv, 1); chk(iw, fw);
        fl <= 0; repeat (2) @(posedge aclk); chk(iw, NOP_WORD);
        start(8'h16);
        while (stall === 1'b1) @(posedge aclk);
        rd(CTRL_ADDR); chk(rdat, 32'h04); chk(n_prog, 1);
        chk(eblk, q[20:10]);
        start(8'h06); aresetn <= 0; @(posedge aclk); aresetn <= 1;
        rd(CTRL_ADDR); chk(rdat, 32'h08); chk(stall, 0);
        rd(8'h21); chk(rres, RESP_SLVERR); chk(rdat, 32'h0);
        axw(8'hE0, 8'h5A); chk(bres, RESP_SLVERR);
        report_and_stop;
    end
endmodule
`default_nettype wire
